// ===== rtl/qdac_map.svh
// offsets, frame field positions, reset values and counts of the command decoder
// assumes a 24-bit frame shifted msb first and a 32-bit register port
`ifndef QDAC_MAP_SVH
`define QDAC_MAP_SVH

// register byte offsets
`define QD_REG_CTRL     8'h00
`define QD_REG_STATUS   8'h04
`define QD_REG_FRAMES   8'h08
`define QD_REG_CODE0    8'h10
`define QD_REG_CODE_LAST 8'h1c

// control and status field positions
`define QD_CTRL_EN      0
`define QD_ST_REF_ON    10
`define QD_EN_RST       1'b1

// frame field positions
`define QD_LD_HI        21
`define QD_LD_LO        20
`define QD_SEL_HI       18
`define QD_SEL_LO       17
`define QD_PD_FLAG      16
`define QD_MODE_HI      15
`define QD_MODE_LO      14
`define QD_REF_HI       13
`define QD_REF_LO       12
`define QD_DATA_HI      15

// frame constants and reset values
`define QD_FRAME_LAST   5'd23
`define QD_SEL_BCAST    2'h2
`define QD_CODE_RST     16'h0000

`endif

// ===== rtl/qdac_pkg.sv
// types shared by the quad converter command decoder
// assumes the constants of qdac_map.svh for positions and offsets
package qdac_pkg;

	// output stage mode, in frame mode-bit order 00..11
	typedef enum logic [1:0] {
		PD_NORMAL,
		PD_1K,
		PD_100K,
		PD_HIZ
	} pd_mode_e;

	// internal reference control
	typedef enum logic [1:0] {
		REF_AUTO,
		REF_ON,
		REF_OFF
	} ref_mode_e;

	// one channel: stage mode and held code
	typedef struct packed {
		pd_mode_e    pd;
		logic [15:0] code;
	} chan_s;

	// whole state of the decoder
	typedef struct packed {
		logic           sclk_s1;
		logic           sclk_s2;
		logic           sclk_s3;
		logic           syn_s1;
		logic           syn_s2;
		logic           din_s1;
		logic           din_s2;
		logic [4:0]     cnt;
		logic [23:0]    shreg;
		logic           done;
		logic           enable;
		chan_s [3:0]    bufs;
		chan_s [3:0]    act;
		ref_mode_e      ref_mode;
		logic           ref_on;
		logic           frame_pulse;
		logic [7:0]     frames;
		logic [31:0]    rd_data;
	} state_s;

endpackage

// ===== rtl/quad_dac_command_decoder.sv
// serial command decoder of a quad 16-bit voltage-output converter
// assumes frame pins from an outside host, sampled by the 100 MHz clock
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "qdac_map.svh"

module quad_dac_command_decoder (
	input  wire logic                       clock,      // 100 MHz system clock
	input  wire logic                       resetn,     // synchronous reset, low
	input  wire logic                       ser_clk,    // serial clock pin
	input  wire logic                       frame_n,    // frame sync pin, low
	input  wire logic                       ser_data,   // serial data pin
	input  wire logic [7:0]                 addr,       // register byte address
	input  wire logic [31:0]                wr_data,    // register write data
	input  wire logic                       wr_en,      // write strobe
	input  wire logic                       rd_en,      // read strobe
	output qdac_pkg::chan_s [3:0]           chan_out,   // active channel settings
	output qdac_pkg::ref_mode_e             ref_mode,   // reference control mode
	output logic                            ref_on,     // reference powered
	output logic                            frame_done, // frame taken pulse
	output logic [31:0]                     rd_data     // read data, next cycle
);

	qdac_pkg::state_s q;
	qdac_pkg::state_s n;
	logic [23:0] fw;
	logic        fall;
	logic        fire;
	logic [1:0]  ld;
	logic [1:0]  sel;
	logic        pdf;
	logic [1:0]  mode;
	logic [1:0]  refb;
	logic        ref_frame;
	logic        bcast;
	logic        valid;
	logic        all_pd;

	// whole next state: pin sampling, frame shift, decode and register port
	always_comb begin
		n = q;
		n.frame_pulse = 1'b0;
		n.rd_data = '0;
		// pins pass two flops, the serial clock three; its second and third stages find the fall
		n.sclk_s1 = ser_clk;
		n.sclk_s2 = q.sclk_s1;
		n.sclk_s3 = q.sclk_s2;
		n.syn_s1 = frame_n;
		n.syn_s2 = q.syn_s1;
		n.din_s1 = ser_data;
		n.din_s2 = q.din_s1;
		fall = q.sclk_s3 & ~q.sclk_s2;
		fw = {q.shreg[22:0], q.din_s2};
		fire = 1'b0;
		// sync high aborts a short frame; extra bits after 24 are ignored
		if (q.syn_s2) begin
			n.cnt = '0;
			n.done = 1'b0;
		end else if (fall && !q.done && q.enable) begin
			n.shreg = fw;
			n.cnt = q.cnt + 5'd1;
			if (q.cnt == `QD_FRAME_LAST) begin
				fire = 1'b1;
				n.done = 1'b1;
			end
		end

		// frame fields
		ld = fw[`QD_LD_HI:`QD_LD_LO];
		sel = fw[`QD_SEL_HI:`QD_SEL_LO];
		pdf = fw[`QD_PD_FLAG];
		mode = fw[`QD_MODE_HI:`QD_MODE_LO];
		refb = fw[`QD_REF_HI:`QD_REF_LO];
		ref_frame = pdf && (ld == 2'h0) && (sel == 2'h0) && (mode == 2'h0);
		bcast = (ld == 2'h3) && (sel == `QD_SEL_BCAST);
		// flag with mode 00 outside the reference frame has no meaning: dropped
		valid = !ref_frame && !(pdf && mode == 2'h0) && !(ld == 2'h3 && !bcast);

		if (fire) begin
			n.frame_pulse = 1'b1;
			n.frames = q.frames + 8'h01;
		end

		// buffer writes first, so a load sees the frame's own content
		for (int i = 0; i < 4; i++) begin
			if (fire && valid && (bcast || sel == 2'(i))) begin
				if (pdf) begin
					n.bufs[i].pd = qdac_pkg::pd_mode_e'(mode);
				end else begin
					n.bufs[i].code = fw[`QD_DATA_HI:0];
					n.bufs[i].pd = qdac_pkg::PD_NORMAL;
				end
			end
		end

		// channel loads: one, all, or none
		for (int i = 0; i < 4; i++) begin
			if (fire && valid) begin
				if (ld == 2'h2 || bcast) begin
					n.act[i] = n.bufs[i];
				end else if (ld == 2'h1 && sel == 2'(i)) begin
					n.act[i] = n.bufs[i];
				end
			end
		end

		// reference control frame
		if (fire && ref_frame) begin
			case (refb)
				2'h0: n.ref_mode = qdac_pkg::REF_AUTO;
				2'h1: n.ref_mode = qdac_pkg::REF_ON;
				2'h2: n.ref_mode = qdac_pkg::REF_OFF;
				default: n.ref_mode = q.ref_mode;
			endcase
		end

		// reference power follows the new channel state in the same edge
		all_pd = 1'b1;
		for (int i = 0; i < 4; i++) begin
			all_pd = all_pd & (n.act[i].pd != qdac_pkg::PD_NORMAL);
		end
		n.ref_on = (n.ref_mode == qdac_pkg::REF_ON) ||
			((n.ref_mode == qdac_pkg::REF_AUTO) && !all_pd);

		// register port: writes land at once, reads answer one cycle later
		if (wr_en && addr == `QD_REG_CTRL) begin
			n.enable = wr_data[`QD_CTRL_EN];
		end
		if (rd_en) begin
			case (addr)
				`QD_REG_CTRL:   n.rd_data = {31'h0, q.enable};
				`QD_REG_STATUS: n.rd_data = {21'h0, q.ref_on, q.ref_mode,
					q.act[3].pd, q.act[2].pd, q.act[1].pd, q.act[0].pd};
				`QD_REG_FRAMES: n.rd_data = {24'h0, q.frames};
				8'h10:          n.rd_data = {16'h0, q.act[0].code};
				8'h14:          n.rd_data = {16'h0, q.act[1].code};
				8'h18:          n.rd_data = {16'h0, q.act[2].code};
				`QD_REG_CODE_LAST: n.rd_data = {16'h0, q.act[3].code};
				default:        n.rd_data = '0;
			endcase
		end
	end

	// state register; reset puts reference in automatic mode, codes at zero
	always_ff @(posedge clock) begin
		if (!resetn) begin
			q <= '0;
			q.syn_s1 <= 1'b1;
			q.syn_s2 <= 1'b1;
			q.enable <= `QD_EN_RST;
			q.ref_mode <= qdac_pkg::REF_AUTO;
			q.ref_on <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state flops
	assign chan_out = q.act;
	assign ref_mode = q.ref_mode;
	assign ref_on = q.ref_on;
	assign frame_done = q.frame_pulse;
	assign rd_data = q.rd_data;

	// checks on the decoder
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_pd_store;
		fire && valid && pdf && ld == 2'h0 |=>
			$stable(q.act) && q.bufs[$past(sel)].pd == $past(mode);
	endproperty
	a_pd_store: assert property (p_pd_store) else $error("pd store changed output");

	property p_load_all;
		fire && valid && ld == 2'h2 |=> q.act == q.bufs;
	endproperty
	a_load_all: assert property (p_load_all) else $error("load all mismatch");

	property p_load_one;
		fire && valid && ld == 2'h1 && !pdf |=>
			q.act[$past(sel)].code == $past(fw[15:0]) && q.act[$past(sel)].pd == qdac_pkg::PD_NORMAL;
	endproperty
	a_load_one: assert property (p_load_one) else $error("single load wrong");

	property p_mode_code;
		fire && valid && pdf && ld == 2'h1 |=> q.act[$past(sel)].pd == $past(mode);
	endproperty
	a_mode_code: assert property (p_mode_code) else $error("mode code wrong");

	property p_bcast;
		fire && bcast && !pdf |=> q.act[0].code == $past(fw[15:0]) &&
			q.act[1].code == $past(fw[15:0]) && q.act[2].code == $past(fw[15:0]) &&
			q.act[3].code == $past(fw[15:0]);
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast wrong");

	property p_ref_on;
		fire && ref_frame && refb == 2'h1 |=> q.ref_mode == qdac_pkg::REF_ON ##1 q.ref_on;
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference not forced on");

	property p_ref_off;
		fire && ref_frame && refb == 2'h2 |=> !q.ref_on [*2];
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference not forced off");

	property p_auto_down;
		q.ref_mode == qdac_pkg::REF_AUTO && q.act[0].pd != qdac_pkg::PD_NORMAL &&
			q.act[1].pd != qdac_pkg::PD_NORMAL && q.act[2].pd != qdac_pkg::PD_NORMAL &&
			q.act[3].pd != qdac_pkg::PD_NORMAL |-> !q.ref_on;
	endproperty
	a_auto_down: assert property (p_auto_down) else $error("auto reference stays up");

	property p_auto_up;
		fire && valid && !pdf && ld != 2'h0 && q.ref_mode == qdac_pkg::REF_AUTO |=> q.ref_on;
	endproperty
	a_auto_up: assert property (p_auto_up) else $error("auto reference not up");

	property p_only_on_fire;
		!$stable(q.act) |-> $past(fire);
	endproperty
	a_only_on_fire: assert property (p_only_on_fire) else $error("update off frame end");

	property p_keep_code;
		fire && pdf |=> $stable(q.bufs[0].code) && $stable(q.bufs[1].code) &&
			$stable(q.bufs[2].code) && $stable(q.bufs[3].code);
	endproperty
	a_keep_code: assert property (p_keep_code) else $error("code lost on pd");

	// broadcast of a stage mode reaches all four outputs at once
	property p_bcast_pd;
		fire && valid && bcast && pdf |=> q.act[0].pd == $past(mode) &&
			q.act[1].pd == $past(mode) && q.act[2].pd == $past(mode) &&
			q.act[3].pd == $past(mode);
	endproperty
	a_bcast_pd: assert property (p_bcast_pd) else $error("broadcast mode wrong");

	// a data frame lands in the buffer that the select bits name
	property p_data_buf;
		fire && valid && !pdf && !bcast |=> q.bufs[$past(sel)].code == $past(fw[15:0]) &&
			q.bufs[$past(sel)].pd == qdac_pkg::PD_NORMAL;
	endproperty
	a_data_buf: assert property (p_data_buf) else $error("data in wrong buffer");

	// a single load leaves channel A alone when another channel is named
	property p_others_keep;
		fire && valid && !pdf && ld == 2'h1 && sel != 2'h0 |=> $stable(q.act[0]);
	endproperty
	a_others_keep: assert property (p_others_keep) else $error("other channel changed");

	// power-down load takes the mode but keeps the held code
	property p_pd_code;
		fire && valid && pdf && ld == 2'h1 |=>
			q.act[$past(sel)].code == $past(q.bufs[sel].code);
	endproperty
	a_pd_code: assert property (p_pd_code) else $error("code lost on pd load");

	// reference frame with bits 00 returns to automatic mode
	property p_ref_auto;
		fire && ref_frame && refb == 2'h0 |=> q.ref_mode == qdac_pkg::REF_AUTO;
	endproperty
	a_ref_auto: assert property (p_ref_auto) else $error("reference not automatic");

	// forced modes hold whatever the channels do
	property p_ref_hold_on;
		q.ref_mode == qdac_pkg::REF_ON |-> q.ref_on;
	endproperty
	a_ref_hold_on: assert property (p_ref_hold_on) else $error("forced reference dropped");

	property p_ref_hold_off;
		q.ref_mode == qdac_pkg::REF_OFF |-> !q.ref_on;
	endproperty
	a_ref_hold_off: assert property (p_ref_hold_off) else $error("forced off reference up");

	// one pulse per frame: the done flag blocks a second fire
	property p_pulse_once;
		q.frame_pulse |=> !q.frame_pulse;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("frame pulse too long");

	c_bcast: cover property (fire && bcast);
	c_ref_off: cover property (fire && ref_frame && refb == 2'h2);
	c_all_down: cover property (q.ref_mode == qdac_pkg::REF_AUTO && !q.ref_on);
	c_seq_load: cover property (fire && ld == 2'h1 && sel == 2'h3);
	c_cut_frame: cover property (q.syn_s2 && !q.done && q.cnt != 5'd0);

endmodule

// ===== tb/host_model.sv
// host side of the serial link: shifts 24-bit frames, cut or overlong ones too
// assumes frames are started by the bench through the send task
`timescale 1ns/1ps
module host_model (
	output logic ser_clk,  // serial clock, idle high
	output logic frame_n,  // frame sync, low inside a frame
	output logic ser_data  // serial data
);
	// idle levels: clock stands still outside frames
	initial begin
		ser_clk = 1'b1;
		frame_n = 1'b1;
		ser_data = 1'b0;
	end

	// data moves on the rising half so it is steady at every fall
	task automatic send(input logic [23:0] f, input int nb);
		frame_n = 1'b0;
		#70;
		// nb below 24 cuts the frame; above 24 adds clocks the decoder must ignore
		for (int k = 0; k < nb; k++) begin
			ser_data = (k < 24) ? f[23 - k] : 1'b1;
			#62.5 ser_clk = 1'b0;
			#62.5 ser_clk = 1'b1;
		end
		#20 ser_data = ~f[0]; // stale level would hide a late sample
		frame_n = 1'b1;
		#100;
	endtask
endmodule

// ===== tb/tb_quad_dac_command_decoder.sv
// bench of the quad converter command decoder: random and corner frames
// assumes host_model drives the serial pins and qdac_map.svh is on the path
`timescale 1ns/1ps
`include "qdac_map.svh"
module tb_quad_dac_command_decoder;
	logic                  clock;
	logic                  resetn;
	logic [7:0]            addr;
	logic [31:0]           wr_data;
	logic                  wr_en;
	logic                  rd_en;
	logic                  ser_clk;
	logic                  frame_n;
	logic                  ser_data;
	qdac_pkg::chan_s [3:0] chan_out;
	qdac_pkg::chan_s [3:0] ea;
	qdac_pkg::chan_s [3:0] eb;
	qdac_pkg::ref_mode_e   ref_mode;
	qdac_pkg::ref_mode_e   em;
	logic                  ref_on;
	logic                  frame_done;
	logic [31:0]           rd_data;
	logic [31:0]           seed = 32'h8;
	logic [31:0]           r;
	logic [7:0]            ef;
	int                    fails = 0;
	int                    comparisons = 0;
	int                    cyc = 0;
	// fixed cases; the first puts the reference in automatic mode
	localparam logic [23:0] corner [22] = '{24'h010000, 24'h10beef, 24'h014000,
		24'h034000, 24'h058000, 24'h278000, 24'h11c000, 24'h13c000, 24'h15c000,
		24'h17c000, 24'h101234, 24'h011000, 24'h35c000, 24'h012000, 24'h34abcd,
		24'h010000, 24'h35c000, 24'h105a5a, 24'h300777, 24'h030000, 24'h16c0ff,
		24'h013000};

	quad_dac_command_decoder quad_dac_command_decoder_inst (.clock(clock), .resetn(resetn),
		.ser_clk(ser_clk), .frame_n(frame_n), .ser_data(ser_data), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .chan_out(chan_out),
		.ref_mode(ref_mode), .ref_on(ref_on), .frame_done(frame_done), .rd_data(rd_data));
	host_model host_model_inst (.ser_clk(ser_clk), .frame_n(frame_n), .ser_data(ser_data));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// hang guard, well above the length of the whole run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			finish_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected effect of one executed frame on buffers, outputs and reference
	function automatic void apply(input logic [23:0] f);
		logic [1:0] ld;
		logic [1:0] sel;
		logic       bc;
		ld = f[21:20];
		sel = f[18:17];
		bc = (ld == 2'h3) && (sel == 2'h2);
		if (f[16] && f[15:14] == 2'h0) begin
			if (ld == 2'h0 && sel == 2'h0 && f[13:12] != 2'h3)
				em = qdac_pkg::ref_mode_e'(f[13:12]);
			return;
		end
		if (ld == 2'h3 && !bc)
			return;
		for (int i = 0; i < 4; i++) begin
			if (bc || i == sel) begin
				if (f[16]) eb[i].pd = qdac_pkg::pd_mode_e'(f[15:14]);
				else eb[i] = {qdac_pkg::PD_NORMAL, f[15:0]};
			end
			if (ld[1] || (ld == 2'h1 && i == sel)) ea[i] = eb[i];
		end
	endfunction

	function automatic logic eref();
		if (em == qdac_pkg::REF_ON) return 1'b1;
		if (em == qdac_pkg::REF_OFF) return 1'b0;
		return ea[0].pd == 0 || ea[1].pd == 0 || ea[2].pd == 0 || ea[3].pd == 0;
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cmp();
		for (int i = 0; i < 4; i++) begin
			chk("chan_out", ea[i], chan_out[i]);
		end
		chk("ref_mode", em, ref_mode);
		chk("ref_on", eref(), ref_on);
	endtask

	// channel outputs must hold until the frame is taken, then channel and reference outputs match the model
	task automatic frame(input logic [23:0] f, input logic ok, input int nb);
		qdac_pkg::chan_s [3:0] old;
		old = chan_out;
		fork
			host_model_inst.send(f, nb);
			begin
				for (int n = 0; n < 400 && frame_done !== 1'b1; n++) begin
					chk("early", 0, chan_out !== old);
					@(posedge clock);
					#1;
				end
				chk("frame_done", ok, frame_done);
			end
		join
		if (ok) begin
			apply(f);
			ef++;
		end
		cmp();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk("rd_data", e, rd_data);
		@(posedge clock);
		#1;
		chk("rd_idle", 32'h0, rd_data);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask

	task automatic reset_all();
		@(posedge clock);
		resetn <= 1'b0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		ea = '0;
		eb = '0;
		em = qdac_pkg::REF_AUTO;
		ef = 8'h00;
		@(posedge clock);
		#1;
		cmp();
	endtask

	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// random frames, corner frames, register port, then a reset in mid-run
	initial begin
		resetn = 1'b0;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		reset_all();
		for (int k = 0; k < 30; k++) begin
			r = rnd();
			frame(r[23:0] & 24'h37ffff, 1'b1, 24);
		end
		foreach (corner[k]) frame(corner[k], 1'b1, 24);
		frame(24'h10beef, 1'b0, 12);
		frame(24'h12abcd, 1'b1, 26);
		rd(`QD_REG_STATUS, {21'h0, eref(), em, ea[3].pd, ea[2].pd, ea[1].pd, ea[0].pd});
		rd(`QD_REG_FRAMES, {24'h0, ef});
		for (int i = 0; i < 4; i++) rd(`QD_REG_CODE0 + 8'(4 * i), {16'h0, ea[i].code});
		rd(8'h40, 32'h0);
		wr(`QD_REG_CTRL, 32'h0);
		rd(`QD_REG_CTRL, 32'h0);
		frame(24'h10aaaa, 1'b0, 24);
		wr(`QD_REG_CTRL, 32'h1);
		rd(`QD_REG_CTRL, 32'h1);
		rd(`QD_REG_FRAMES, {24'h0, ef});
		frame(24'h012000, 1'b1, 24);
		reset_all();
		frame(24'h100123, 1'b1, 24);
		finish_test();
	end
endmodule
